// >>> bench/lpc_partner.sv
// lpc_partner: far side model with link detect, capability and identifier
// pulses, and a forward channel sink that stalls at random.
// assumes: the bench seeds $urandom and calls the tasks at a clock edge.
`default_nettype none

module lpc_partner (
    input wire logic aclk,
    output logic link_det,
    output logic caps_v,
    output logic st,
    output logic mp,
    output logic [3:0] port,
    output logic id_v,
    output logic [6:0] id,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        link_det = 1'b0;
        caps_v = 1'b0;
        id_v = 1'b0;
        {st, mp, port} = 6'h2a;
        id = 7'h55;
        tx_ready = 1'b0;
    end

    task automatic link(input logic up);
        @(posedge aclk);
        link_det <= up;
    endtask : link

    // one-cycle pulse; the payload is scrambled once the pulse is over
    task automatic caps(input logic [5:0] v);
        @(posedge aclk);
        caps_v <= 1'b1;
        {st, mp, port} <= v;
        @(posedge aclk);
        caps_v <= 1'b0;
        {st, mp, port} <= ~v;
    endtask : caps

    task automatic ident(input logic [6:0] v);
        @(posedge aclk);
        id_v <= 1'b1;
        id <= v;
        @(posedge aclk);
        id_v <= 1'b0;
        id <= ~v;
    endtask : ident

    // sink stalls about one cycle in four
    always @(posedge aclk) begin
        tx_ready <= ($urandom % 4) != 0;
    end

endmodule : lpc_partner

`default_nettype wire

// >>> bench/lpc_regs_test.sv
// lpc_regs_test: self-checking bench for the link partner capability bank.
// assumes: lpc_partner drives the far side; one clock at 200 MHz.
`default_nettype none

module lpc_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    import lpc_pkg::*;

    localparam logic [6:0] IDR = 7'h15;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic seq_valid = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, seq_byte = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, seq_ready, tx_valid, link_up, tx_ready;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] tx_byte;
    logic [3:0] fwd_gpio_lane_en, partner_port_index, cc_port_index;
    logic partner_selftest_request, partner_multiport_flag;
    logic [6:0] remote_deser_identifier, cc_ident;
    logic bc_link_detect, cc_caps_valid, cc_selftest, cc_multiport, cc_ident_valid;
    logic [3:0] lane [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
    int fails = 0;
    int cmp_count = 0;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [3:0] wr_strb = 4'hf;
    logic [7:0] tx_q[$];

    initial forever #2.5 aclk = ~aclk;

    lpc_regs #(.IDENT_RESET(IDR)) i_dut (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
        .rready, .rdata, .rresp, .bc_link_detect, .cc_caps_valid, .cc_selftest, .cc_multiport,
        .cc_port_index, .cc_ident_valid, .cc_ident, .seq_valid, .seq_ready, .seq_byte, .tx_valid,
        .tx_ready, .tx_byte, .fwd_gpio_lane_en, .link_up, .partner_selftest_request,
        .partner_multiport_flag, .partner_port_index, .remote_deser_identifier
    );

    lpc_partner i_far (
        .aclk, .link_det(bc_link_detect), .caps_v(cc_caps_valid), .st(cc_selftest),
        .mp(cc_multiport), .port(cc_port_index), .id_v(cc_ident_valid), .id(cc_ident), .tx_ready
    );

    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : chk

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    // results are compared in order against the notes left by the drivers
    always @(posedge aclk) begin
        if (bvalid === 1'b1 && bready) begin
            chk("bresp", wr_q.size() > 0 ? 34'(wr_q.pop_front()) : '1, 34'(bresp));
        end
        if (rvalid === 1'b1 && rready) begin
            chk("rdata", rd_q.size() > 0 ? rd_q.pop_front() : '1, {rresp, rdata});
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            chk("tx_byte", tx_q.size() > 0 ? 34'(tx_q.pop_front()) : '1, 34'(tx_byte));
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
        wr_q.push_back(resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= wr_strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
        rd_q.push_back({resp, 24'h0, d});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
    endtask : rd

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
        return r;
    endfunction : crc_step

    // eight bytes; seq_valid is left high so frames can run back to back
    task automatic frame(input logic csum);
        logic [7:0] b;
        logic [7:0] c;
        c = 8'h00;
        for (int k = 0; k < 8; k++) begin
            b = 8'($urandom);
            c = crc_step(c, b);
            tx_q.push_back(b);
            seq_valid <= 1'b1;
            seq_byte <= b;
            do @(posedge aclk); while (seq_ready !== 1'b1);
        end
        if (csum) tx_q.push_back(c);
    endtask : frame

    task automatic drain;
        seq_valid <= 1'b0;
        for (int n = 0; n < 200 && tx_q.size() > 0; n++) @(posedge aclk);
        chk("tx_left", 34'h0, 34'(tx_q.size()));
    endtask : drain

    task automatic wait_link(input logic up);
        for (int n = 0; n < 50 && link_up !== up; n++) @(posedge aclk);
        chk("link_up", 34'(up), 34'(link_up));
    endtask : wait_link

    initial begin
        logic [5:0] cv;
        logic [6:0] iv;
        void'($urandom(32'hee20));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            rd(8'(8'hcc + 4 * a), a == 4 ? {IDR, 1'b0} : 8'h00, RESP_OKAY);
        end
        rd(8'hf0, 8'h00, RESP_SLVERR);
        wr(8'hf0, 8'hff, RESP_SLVERR);
        // a write with byte lane 0 off is answered but stores nothing
        wr_strb = 4'h0;
        wr(8'hcc, 8'hff, RESP_OKAY);
        wr_strb = 4'hf;
        rd(8'hcc, 8'h00, RESP_OKAY);
        $display("test reset done");
        for (int g = 0; g < 4; g++) begin
            wr(8'hcc, 8'(g), RESP_OKAY);
            @(posedge aclk);
            #1 chk("lane_en", 34'(lane[g]), 34'(fwd_gpio_lane_en));
            rd(8'hcc, 8'(g), RESP_OKAY);
        end
        $display("test gpio done");
        i_far.link(1'b1);
        wait_link(1'b1);
        cv = 6'($urandom);
        i_far.caps(cv);
        #1 chk("caps", 34'(cv), 34'({partner_selftest_request, partner_multiport_flag,
            partner_port_index}));
        rd(8'hd4, {2'b00, cv}, RESP_OKAY);
        iv = 7'($urandom);
        i_far.ident(iv);
        #1 chk("ident", 34'(iv), 34'(remote_deser_identifier));
        rd(8'hdc, {iv, 1'b0}, RESP_OKAY);
        $display("test autoload done");
        cv = 6'($urandom);
        iv = 7'($urandom);
        wr(8'hd4, {2'b10, cv}, RESP_OKAY);
        wr(8'hdc, {iv, 1'b1}, RESP_OKAY);
        i_far.caps(~cv);
        i_far.ident(~iv);
        #1 chk("caps_held", 34'(cv), 34'({partner_selftest_request, partner_multiport_flag,
            partner_port_index}));
        chk("ident_held", 34'(iv), 34'(remote_deser_identifier));
        rd(8'hd4, {2'b10, cv}, RESP_OKAY);
        rd(8'hdc, {iv, 1'b1}, RESP_OKAY);
        $display("test hold done");
        wr(8'hd4, {2'b00, cv}, RESP_OKAY);
        wr(8'hdc, {iv, 1'b0}, RESP_OKAY);
        i_far.link(1'b0);
        wait_link(1'b0);
        i_far.link(1'b1);
        wait_link(1'b1);
        i_far.caps(~cv);
        i_far.ident(~iv);
        rd(8'hd4, {2'b00, ~cv}, RESP_OKAY);
        rd(8'hdc, {~iv, 1'b0}, RESP_OKAY);
        $display("test refresh done");
        wr(8'hcc, 8'(1 << DP_CSUM_BIT), RESP_OKAY);
        frame(1'b1);
        frame(1'b1);
        drain;
        wr(8'hcc, 8'h00, RESP_OKAY);
        frame(1'b0);
        drain;
        $display("test checksum done");
        chk("reads_left", 34'h0, 34'(rd_q.size() + wr_q.size()));
        give_verdict;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        give_verdict;
    end

endmodule : lpc_regs_test

`default_nettype wire

// >>> rtl/lpc_crc8.sv
// lpc_crc8: byte-wide CRC-8 accumulator, msb first.
// assumes: clear and enable come from logic on the same clock.
`default_nettype none

module lpc_crc8 #(
    parameter logic [7:0] POLY = lpc_pkg::CRC_POLY_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic enable,
    input wire logic [7:0] data_in,
    output logic [7:0] crc_out
);
    import lpc_pkg::*;

    function automatic logic [7:0] lpc_crc_step(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
        end
        return c;
    endfunction : lpc_crc_step

    // clear wins so a finished sequence never leaks into the next one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_out <= CRC_INIT;
        end else if (clear) begin
            crc_out <= CRC_INIT;
        end else if (enable) begin
            crc_out <= lpc_crc_step(crc_out, data_in);
        end
    end

endmodule : lpc_crc8

`default_nettype wire

// >>> rtl/lpc_pkg.sv
// lpc_pkg: register map, field layout, reset values and types of the
// link partner capability register bank.
// assumes: an AXI4-Lite master with 32-bit data and one register per word.
`default_nettype none

package lpc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_DATAPATH_CONTROL_ONE = 6'h33;
    localparam logic [5:0] IDX_RESERVED_BLOCK_A = 6'h34;
    localparam logic [5:0] IDX_PARTNER_CAPABILITIES_ONE = 6'h35;
    localparam logic [5:0] IDX_RESERVED_BLOCK_B = 6'h36;
    localparam logic [5:0] IDX_REMOTE_DESER_IDENTIFIER = 6'h37;
    localparam logic [5:0] IDX_RESERVED_BLOCK_C = 6'h38;

    // slots inside the bank, counted from the first index
    localparam logic [2:0] SLOT_DP = 3'h0;
    localparam logic [2:0] SLOT_RSVD_A = 3'h1;
    localparam logic [2:0] SLOT_CAPS = 3'h2;
    localparam logic [2:0] SLOT_RSVD_B = 3'h3;
    localparam logic [2:0] SLOT_IDENT = 3'h4;
    localparam logic [2:0] SLOT_RSVD_C = 3'h5;
    localparam logic [2:0] SLOT_NONE = 3'h7;

    // field positions
    localparam int unsigned DP_CSUM_BIT = 2;
    localparam int unsigned DP_GPIO_LSB = 0;
    localparam int unsigned CAP_HOLD_BIT = 7;
    localparam int unsigned CAP_SELFTEST_BIT = 5;
    localparam int unsigned CAP_MULTIPORT_BIT = 4;
    localparam int unsigned CAP_PORT_LSB = 0;
    localparam int unsigned ID_LSB = 1;
    localparam int unsigned ID_HOLD_BIT = 0;

    // reset values
    localparam logic [7:0] DP_CTRL_RST = 8'h00;
    localparam logic [7:0] CAPS_RST = 8'h00;
    localparam logic [7:0] RSVD_RST = 8'h00;
    localparam logic [6:0] IDENT_RST_DEFAULT = 7'h2a; // arbitrary value
    localparam logic ID_HOLD_RST = 1'b0;

    // control sequence checksum
    localparam logic [2:0] SEQ_LAST_BYTE = 3'h7;
    localparam logic [7:0] CRC_POLY_DEFAULT = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {
        LPC_TX_PASS,
        LPC_TX_CRC
    } lpc_tx_state_t;

endpackage : lpc_pkg

`default_nettype wire

// >>> rtl/lpc_regs.sv
// lpc_regs: link partner capability and datapath control registers with
// control sequence checksum insertion, behind an AXI4-Lite slave.
// assumes: control channel inputs are on aclk; link detect is a raw pin.
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none

// Operation
// - checksum enable set appends a CRC byte to every control sequence.
// - CRC covers the first eight bytes and goes out as byte nine.
// - gpio count field enables none, one, two or four forward GPIOs.
// - capability hold bit blocks auto-load and keeps software values.
// - self-test request bit shows the partner asks for link self-test.
// - multiport flag is 0 for single-port and 1 for multi-port partner.
// - port index holds the partner port this serializer connects to.
// - control channel loads self-test, multiport and port after link detect.
// - remote deserializer identifier is loaded from the remote side.
// - identifier hold bit stops loading and keeps the software value.
module lpc_regs #(
    parameter logic [6:0] IDENT_RESET = lpc_pkg::IDENT_RST_DEFAULT,
    parameter logic [7:0] CRC_POLY = lpc_pkg::CRC_POLY_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [lpc_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [lpc_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [lpc_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [lpc_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    input wire logic bc_link_detect,
    input wire logic cc_caps_valid,
    input wire logic cc_selftest,
    input wire logic cc_multiport,
    input wire logic [3:0] cc_port_index,
    input wire logic cc_ident_valid,
    input wire logic [6:0] cc_ident,
    input wire logic seq_valid,
    output logic seq_ready,
    input wire logic [7:0] seq_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_byte,
    output logic [3:0] fwd_gpio_lane_en,
    output logic link_up,
    output logic partner_selftest_request,
    output logic partner_multiport_flag,
    output logic [3:0] partner_port_index,
    output logic [6:0] remote_deser_identifier
);
    import lpc_pkg::*;

    function automatic logic [2:0] lpc_slot(input logic [ADDR_W-1:0] a);
        logic [5:0] idx;
        idx = a[ADDR_W-1:2];
        if (a[1:0] != 2'h0 || idx < IDX_DATAPATH_CONTROL_ONE || idx > IDX_RESERVED_BLOCK_C) begin
            return SLOT_NONE;
        end
        return 3'(idx - IDX_DATAPATH_CONTROL_ONE);
    endfunction : lpc_slot

    function automatic logic [3:0] lpc_gpio_lanes(input logic [1:0] sel);
        case (sel)
            2'h0: return 4'h0;
            2'h1: return 4'h1;
            2'h2: return 4'h3;
            default: return 4'hf;
        endcase
    endfunction : lpc_gpio_lanes

    logic [7:0] dp_ctrl_reg;
    logic [7:0] rsvd_a_reg;
    logic [7:0] caps_reg;
    logic [7:0] rsvd_b_reg;
    logic [6:0] ident_reg;
    logic ident_hold_reg;
    logic [7:0] rsvd_c_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [7:0] wbyte_reg;
    logic wstrb0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [2:0] link_sync_reg;
    logic link_up_reg;
    lpc_tx_state_t tx_state_reg;
    logic [2:0] byte_cnt_reg;
    logic tx_valid_reg;
    logic [7:0] tx_byte_reg;
    logic [3:0] gpio_lane_reg;
    logic [7:0] crc_val;
    logic wr_fire;
    logic [2:0] wr_slot;
    logic wr_en;
    logic caps_load;
    logic ident_load;
    logic slot_free;
    logic seq_take;
    logic seq_end;
    logic crc_emit;
    logic [7:0] rd_byte;
    logic [2:0] rd_slot;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // axi4-lite slave
    assign awready = !aw_held_reg;
    assign wready = !w_held_reg;
    assign arready = !rvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_slot = lpc_slot(awaddr_reg);
    assign wr_en = wr_fire && wstrb0_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wbyte_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wbyte_reg <= wdata[7:0];
            wstrb0_reg <= wstrb[0];
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_slot == SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign rd_slot = lpc_slot(araddr);

    always_comb begin
        case (rd_slot)
            SLOT_DP: rd_byte = dp_ctrl_reg;
            SLOT_RSVD_A: rd_byte = rsvd_a_reg;
            SLOT_CAPS: rd_byte = caps_reg;
            SLOT_RSVD_B: rd_byte = rsvd_b_reg;
            SLOT_IDENT: rd_byte = {ident_reg, ident_hold_reg};
            SLOT_RSVD_C: rd_byte = rsvd_c_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h000000, rd_byte};
            rresp_reg <= (rd_slot == SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // plain software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dp_ctrl_reg <= DP_CTRL_RST;
            rsvd_a_reg <= RSVD_RST;
            rsvd_b_reg <= RSVD_RST;
            rsvd_c_reg <= RSVD_RST;
        end else if (wr_en) begin
            if (wr_slot == SLOT_DP) begin
                dp_ctrl_reg <= wbyte_reg;
            end
            if (wr_slot == SLOT_RSVD_A) begin
                rsvd_a_reg <= wbyte_reg;
            end
            if (wr_slot == SLOT_RSVD_B) begin
                rsvd_b_reg <= wbyte_reg;
            end
            if (wr_slot == SLOT_RSVD_C) begin
                rsvd_c_reg <= wbyte_reg;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gpio_lane_reg <= 4'h0;
        end else begin
            gpio_lane_reg <= lpc_gpio_lanes(dp_ctrl_reg[DP_GPIO_LSB +: 2]);
        end
    end
    assign fwd_gpio_lane_en = gpio_lane_reg;

    // back-channel link detect
    // three stages; level moves only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_sync_reg <= 3'h0;
            link_up_reg <= 1'b0;
        end else begin
            link_sync_reg <= {link_sync_reg[1:0], bc_link_detect};
            if (link_sync_reg[1] == link_sync_reg[2]) begin
                link_up_reg <= link_sync_reg[2];
            end
        end
    end
    assign link_up = link_up_reg;

    // partner capabilities and identifier
    assign caps_load = cc_caps_valid && link_up_reg && !caps_reg[CAP_HOLD_BIT];
    assign ident_load = cc_ident_valid && link_up_reg && !ident_hold_reg;

    // an auto-load in the same cycle as a software write wins over it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            caps_reg <= CAPS_RST;
        end else begin
            if (wr_en && wr_slot == SLOT_CAPS) begin
                caps_reg <= wbyte_reg;
            end
            if (caps_load) begin
                caps_reg[CAP_SELFTEST_BIT] <= cc_selftest;
                caps_reg[CAP_MULTIPORT_BIT] <= cc_multiport;
                caps_reg[CAP_PORT_LSB +: 4] <= cc_port_index;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ident_reg <= IDENT_RESET;
            ident_hold_reg <= ID_HOLD_RST;
        end else begin
            if (wr_en && wr_slot == SLOT_IDENT) begin
                ident_reg <= wbyte_reg[ID_LSB +: 7];
                ident_hold_reg <= wbyte_reg[ID_HOLD_BIT];
            end
            if (ident_load) begin
                ident_reg <= cc_ident;
            end
        end
    end

    assign partner_selftest_request = caps_reg[CAP_SELFTEST_BIT];
    assign partner_multiport_flag = caps_reg[CAP_MULTIPORT_BIT];
    assign partner_port_index = caps_reg[CAP_PORT_LSB +: 4];
    assign remote_deser_identifier = ident_reg;

    // control sequence checksum insertion
    assign slot_free = !tx_valid_reg || tx_ready;
    assign seq_ready = (tx_state_reg == LPC_TX_PASS) && slot_free;
    assign seq_take = seq_valid && seq_ready;
    assign seq_end = seq_take && (byte_cnt_reg == SEQ_LAST_BYTE);
    assign crc_emit = (tx_state_reg == LPC_TX_CRC) && slot_free;

    lpc_crc8 #(
        .POLY(CRC_POLY)
    ) u_crc (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(crc_emit || (seq_end && !dp_ctrl_reg[DP_CSUM_BIT])),
        .enable(seq_take),
        .data_in(seq_byte),
        .crc_out(crc_val)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state_reg <= LPC_TX_PASS;
            byte_cnt_reg <= 3'h0;
        end else begin
            case (tx_state_reg)
                LPC_TX_PASS: begin
                    if (seq_take) begin
                        byte_cnt_reg <= byte_cnt_reg + 3'h1;
                    end
                    if (seq_end && dp_ctrl_reg[DP_CSUM_BIT]) begin
                        tx_state_reg <= LPC_TX_CRC;
                    end
                end
                LPC_TX_CRC: begin
                    if (crc_emit) begin
                        tx_state_reg <= LPC_TX_PASS;
                    end
                end
                default: tx_state_reg <= LPC_TX_PASS;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_valid_reg <= 1'b0;
            tx_byte_reg <= 8'h00;
        end else if (seq_take) begin
            tx_valid_reg <= 1'b1;
            tx_byte_reg <= seq_byte;
        end else if (crc_emit) begin
            tx_valid_reg <= 1'b1;
            tx_byte_reg <= crc_val;
        end else if (tx_ready) begin
            tx_valid_reg <= 1'b0;
        end
    end
    assign tx_valid = tx_valid_reg;
    assign tx_byte = tx_byte_reg;

    // assertions

    property p_crc_appended;
        seq_end && dp_ctrl_reg[DP_CSUM_BIT] |=> tx_state_reg == LPC_TX_CRC && !seq_ready;
    endproperty
    a_crc_appended: assert property (p_crc_appended)
        else $error("checksum byte not scheduled after eighth byte");

    property p_no_crc_when_off;
        seq_end && !dp_ctrl_reg[DP_CSUM_BIT] |=> tx_state_reg == LPC_TX_PASS && byte_cnt_reg == 3'h0;
    endproperty
    a_no_crc_when_off: assert property (p_no_crc_when_off)
        else $error("checksum state entered while checksum off");

    property p_crc_ninth_byte;
        crc_emit |=> tx_valid_reg && tx_byte_reg == $past(crc_val) && byte_cnt_reg == 3'h0;
    endproperty
    a_crc_ninth_byte: assert property (p_crc_ninth_byte)
        else $error("ninth byte is not the running checksum");

    property p_gpio_lanes;
        dp_ctrl_reg[1:0] == 2'h3 ##1 dp_ctrl_reg[1:0] == 2'h3 |-> fwd_gpio_lane_en == 4'hf;
    endproperty
    a_gpio_lanes: assert property (p_gpio_lanes)
        else $error("four gpio lanes not enabled");

    property p_gpio_one;
        dp_ctrl_reg[1:0] == 2'h1 |=> fwd_gpio_lane_en == 4'h1;
    endproperty
    a_gpio_one: assert property (p_gpio_one)
        else $error("single gpio lane decode wrong");

    property p_caps_hold;
        caps_reg[CAP_HOLD_BIT] && !(wr_en && wr_slot == SLOT_CAPS) |=> $stable(caps_reg);
    endproperty
    a_caps_hold: assert property (p_caps_hold)
        else $error("held capabilities changed");

    property p_caps_load;
        caps_load |=> partner_selftest_request == $past(cc_selftest)
            && partner_multiport_flag == $past(cc_multiport)
            && partner_port_index == $past(cc_port_index);
    endproperty
    a_caps_load: assert property (p_caps_load)
        else $error("capabilities not loaded from control channel");

    property p_selftest_shown;
        caps_load && cc_selftest |=> partner_selftest_request;
    endproperty
    a_selftest_shown: assert property (p_selftest_shown)
        else $error("self-test request not shown");

    property p_multiport_shown;
        caps_load && !cc_multiport |=> !partner_multiport_flag;
    endproperty
    a_multiport_shown: assert property (p_multiport_shown)
        else $error("single-port partner shown as multi-port");

    property p_port_index;
        caps_load && cc_multiport |=> partner_port_index == $past(cc_port_index);
    endproperty
    a_port_index: assert property (p_port_index)
        else $error("partner port index not captured");

    property p_ident_load;
        ident_load |=> remote_deser_identifier == $past(cc_ident);
    endproperty
    a_ident_load: assert property (p_ident_load)
        else $error("remote identifier not loaded");

    property p_ident_hold;
        ident_hold_reg && !(wr_en && wr_slot == SLOT_IDENT) |=> $stable(ident_reg);
    endproperty
    a_ident_hold: assert property (p_ident_hold)
        else $error("held identifier changed");

    property p_link_rise;
        !link_up_reg && link_sync_reg[1] && link_sync_reg[2] |=> link_up_reg;
    endproperty
    a_link_rise: assert property (p_link_rise)
        else $error("link detect not recognised after agreement");

endmodule : lpc_regs

`default_nettype wire
